// >>> tb/pgp_pads.sv
`timescale 1ns/1ps
module pgp_pads (
  // chip side
  input  wire [7:0] out,
  input  wire [7:0] oe_n,
  input  wire [7:0] pu,
  // board side drive
  input  wire [7:0] ext,
  // resolved pad level
  output wire [7:0] pin
);
  // released pins show the pull-up, else what the board drives
  assign pin = (out & ~oe_n) | (oe_n & (pu | ext));
endmodule

// >>> tb/pgp_port34_checker.sv
`timescale 1ns/1ps
module pgp_port34_checker (
  // clock and reset
  input wire       ref_clk,
  input wire       rst_n,
  // bus
  input wire       read,
  input wire       write,
  input wire       waitrequest,
  // device state
  input wire [1:0] mode_pins,
  input wire       hw_standby_n,
  input wire       sw_standby,
  input wire       slave_mode,
  input wire       periph_reinit,
  // pins
  input wire [7:0] p3_pullup_en,
  input wire [7:0] p3_oe_n,
  input wire [7:0] p3_out,
  input wire [7:0] p4_oe_n,
  input wire [7:0] ext_bus_out,
  input wire       ext_bus_drive
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  wait_once_a: assert property ($fell(waitrequest) |=> waitrequest)
    else $error("waitrequest low longer than one cycle");
  bus_answer_a: assert property ((read || write) && waitrequest
    |=> !waitrequest) else $error("request not answered next cycle");
  slave_pullup_a: assert property (slave_mode[*2] |-> p3_pullup_en == 8'h00)
    else $error("pull-up on in slave mode");
  mode1_pullup_a: assert property ((rst_n && mode_pins == 2'h1)[*4]
    |-> p3_pullup_en == 8'h00) else $error("pull-up on in mode 1");
  clk_pin_a: assert property ((rst_n && hw_standby_n &&
    mode_pins != 2'h3 && mode_pins != 2'h0)[*5] |-> !p4_oe_n[6])
    else $error("clock pin not driven in expanded mode");
  ext_bus_a: assert property ((rst_n && hw_standby_n &&
    mode_pins == 2'h2)[*5] ##0 (ext_bus_drive && !sw_standby)
    |=> p3_oe_n == 8'h00 && p3_out == $past(ext_bus_out))
    else $error("port 3 not carrying the data bus");
  reinit_a: assert property (sw_standby ##1 sw_standby |-> periph_reinit)
    else $error("peripherals not reinitialised in standby");
  mode1_slave_a: assert property ((rst_n && mode_pins == 2'h1)[*4]
    |-> !slave_mode) else $error("slave mode outside single-chip");
endmodule

// >>> tb/pgp_port34_test.sv
`timescale 1ns/1ps
`include "pgp_defines.vh"
module pgp_port34_test;
  logic ref_clk = 0, rst_n = 0, read = 0, write = 0, hw_standby_n = 1;
  logic sw_standby = 0, ext_bus_drive = 0;
  logic [17:0] address = 0;
  logic [31:0] writedata = 0;
  logic [1:0] mode_pins = 2'h3;
  logic [7:0] ext3 = 0, ext4 = 8'h40, ext_bus_out = 0;
  logic [7:0] periph_out = 0, periph_drive = 0, q;
  logic [3:0] byteenable = 4'h1;
  wire [31:0] readdata;
  wire waitrequest, periph_reinit, slave_mode;
  wire [7:0] p3_in, p3_out, p3_oe_n, p3_pullup_en, p4_in, p4_out, p4_oe_n;
  int miscompares = 0, num_checks = 0;
  pgp_port34 i_dut (.ref_clk, .rst_n, .address, .read, .write,
    .byteenable, .writedata, .readdata, .waitrequest, .mode_pins,
    .hw_standby_n, .sw_standby, .p3_in, .p3_out, .p3_oe_n, .p3_pullup_en,
    .ext_bus_out, .ext_bus_drive, .host_bus_out(8'h00),
    .host_bus_drive(1'b0), .p3_data_in(), .p4_in, .p4_out, .p4_oe_n,
    .periph_out, .periph_drive, .host_irq(3'h0), .sys_clk_level(1'b0),
    .p4_data_in(), .periph_reinit, .slave_mode);
  pgp_pads i_p3 (.out(p3_out), .oe_n(p3_oe_n), .pu(p3_pullup_en),
    .ext(ext3), .pin(p3_in));
  pgp_pads i_p4 (.out(p4_out), .oe_n(p4_oe_n), .pu(8'h00), .ext(ext4),
    .pin(p4_in));
  ////////////////////////////////////////////////////////////////////////
  task cy(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task acc(input logic w, input logic [15:0] i, input logic [7:0] d);
    @(posedge ref_clk);
    address <= {i, 2'b00};
    writedata <= {24'h00_0000, d};
    read <= !w;
    write <= w;
    // wait until waitrequest goes low; only the watchdog ends a wait that never does
    do begin
      @(posedge ref_clk);
    end while (waitrequest !== 1'b0);
    q = readdata[7:0];
    read <= 0;
    write <= 0;
  endtask
  task wr(input logic [15:0] i, input logic [7:0] d);
    acc(1, i, d);
  endtask
  task rd(input logic [15:0] i, input logic [7:0] e);
    acc(0, i, 8'h00);
    chk(q, e);
  endtask
  task rst(input logic [1:0] m);
    rst_n <= 0;
    mode_pins <= m;
    cy(16);
    rst_n <= 1;
    cy(2);
  endtask
  task tally_and_finish;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial forever #2.5 ref_clk = ~ref_clk;
  initial begin
    cy(20000);
    miscompares++;
    tally_and_finish;
  end
  initial begin
    rst(2'h3);
    chk(p3_pullup_en, 8'h00);
    chk(p4_oe_n, 8'hff);
    rd(`PGP_IDX_P3_PULLUP, 8'h00);
    rd(`PGP_IDX_P4_DIR, 8'hff);
    rd(`PGP_IDX_P4_LATCH, 8'h40);
    rd(16'h0000, 8'h00);
    wr(`PGP_IDX_P3_PULLUP, 8'hff);
    wr(`PGP_IDX_P3_DIR, 8'h0f);
    wr(`PGP_IDX_P3_LATCH, 8'h5a);
    cy(4);
    chk(p3_pullup_en, 8'hf0);
    chk(p3_oe_n, 8'hf0);
    rd(`PGP_IDX_P3_LATCH, 8'hfa);
    wr(`PGP_IDX_P4_DIR, 8'h0f);
    wr(`PGP_IDX_P4_LATCH, 8'h3c);
    ext4 <= 8'ha0;
    periph_out <= 8'h80;
    periph_drive <= 8'h80;
    cy(4);
    chk(p4_oe_n, 8'h70);
    rd(`PGP_IDX_P4_LATCH, 8'hac);
    sw_standby <= 1;
    cy(3);
    chk(p4_oe_n, 8'hf0);
    chk({7'h00, periph_reinit}, 8'h01);
    chk(p3_pullup_en, 8'hf0);
    sw_standby <= 0;
    wr(`PGP_IDX_SYS_CTRL, 8'h01);
    cy(3);
    chk({7'h00, slave_mode}, 8'h01);
    chk(p3_pullup_en, 8'h00);
    wr(`PGP_IDX_P3_DIR, 8'h00);
    wr(`PGP_IDX_P3_LATCH, 8'h00);
    rd(`PGP_IDX_STATUS, 8'h07);
    hw_standby_n <= 0;
    cy(5);
    chk(p3_oe_n, 8'hff);
    hw_standby_n <= 1;
    periph_drive <= 8'h00;
    cy(5);
    rd(`PGP_IDX_P3_PULLUP, 8'h00);
    byteenable <= 4'h0;
    wr(`PGP_IDX_P3_PULLUP, 8'h55);
    byteenable <= 4'h1;
    rd(`PGP_IDX_P3_PULLUP, 8'h00);
    rst(2'h1);
    chk(p4_oe_n, 8'hbf);
    wr(`PGP_IDX_P4_DIR, 8'h00);
    wr(`PGP_IDX_P3_PULLUP, 8'hff);
    wr(`PGP_IDX_SYS_CTRL, 8'h01);
    cy(4);
    chk(p4_oe_n, 8'hbf);
    chk(p3_pullup_en, 8'h00);
    chk({7'h00, slave_mode}, 8'h00);
    rst(2'h2);
    chk(p4_oe_n, 8'hbf);
    ext_bus_out <= 8'h96;
    ext_bus_drive <= 1;
    cy(4);
    chk(p3_oe_n, 8'h00);
    chk(p3_out, 8'h96);
    ext_bus_drive <= 0;
    cy(2);
    tally_and_finish;
  end
endmodule
bind pgp_port34 pgp_port34_checker i_chk (.ref_clk, .rst_n, .read, .write,
  .waitrequest, .mode_pins, .hw_standby_n, .sw_standby, .slave_mode,
  .periph_reinit, .p3_pullup_en, .p3_oe_n, .p3_out, .p4_oe_n,
  .ext_bus_out, .ext_bus_drive);

// >>> verilog/pgp_defines.vh
`ifndef PGP_DEFINES_VH
`define PGP_DEFINES_VH

// register indices; byte address is four times the index
`define PGP_IDX_P3_PULLUP    16'hFFAE
`define PGP_IDX_P3_DIR       16'hFFB4
`define PGP_IDX_P4_DIR       16'hFFB5
`define PGP_IDX_P3_LATCH     16'hFFB6
`define PGP_IDX_P4_LATCH     16'hFFB7
`define PGP_IDX_SYS_CTRL     16'hFFF0
`define PGP_IDX_STATUS       16'hFFF1

// system_control_reg fields
`define PGP_SYS_HIE_BIT      0

// status fields
`define PGP_ST_MODE_LO       0
`define PGP_ST_MODE_HI       1
`define PGP_ST_SLAVE_BIT     2
`define PGP_ST_SWSTBY_BIT    3

// mode pin codes
`define PGP_MODE_1           2'h1
`define PGP_MODE_2           2'h2
`define PGP_MODE_3           2'h3

// reset values
`define PGP_P3_PULLUP_RST    8'h00
`define PGP_P3_DIR_RST       8'h00
`define PGP_P3_LATCH_RST     8'h00
`define PGP_P4_DIR_RST_EXP   8'h40
`define PGP_P4_DIR_RST_SGL   8'h00
`define PGP_P4_LATCH_RST     8'h00
`define PGP_WO_READ          8'hFF

// port 4 pin roles
`define PGP_P4_CLK_PIN       6
`define PGP_P4_HIRQ_LO       3
`define PGP_P4_HIRQ_HI       5

`endif

// >>> verilog/pgp_port34.v
// Notes on behaviour
// - port 3 pull-up on only when its enable bit is 1 and direction is 0
// - pull-up enables clear on reset and hardware standby, kept in soft standby
// - slave mode with host interface forces all port 3 pull-ups off
// - modes 1 and 2: port 3 is the external data bus, direction ignored
// - mode 3 with host interface enable 0: port 3 is plain I/O
// - host interface enable 1 in slave mode: port 3 is the host data bus
// - pull-ups off in mode 1 always, and in reset or hardware standby
// - port 4 direction bit 1 makes the pin output, 0 input
// - modes 1 and 2: port 4 pin 6 direction held at 1, drives clock
// - port 4 direction is write-only and reads as all ones
// - port 4 direction resets to 0x40 in modes 1, 2 and 0x00 in mode 3
// - soft standby resets peripherals; port 4 pins they drive revert to plain I/O
// - port 4 latch bit 6 is read-only pin level; other bits reset 0
// - port 4 slave-mode host functions only in single-chip mode
// - mode 3: port 3 direction 1 gives output, 0 gives input
// - port 3 read gives latch for outputs, pin level for inputs
// - port 4 read gives latch for outputs, pin level else; pin 6 always pin
`timescale 1ns/1ps
`include "pgp_defines.vh"
module pgp_port34 (
  // clock and reset
  input  wire        ref_clk,
  input  wire        rst_n,
  // avalon-mm slave
  input  wire [17:0] address,
  input  wire        read,
  input  wire        write,
  input  wire [3:0]  byteenable,
  input  wire [31:0] writedata,
  output wire [31:0] readdata,
  output wire        waitrequest,
  // device state pins and signals
  input  wire [1:0]  mode_pins,
  input  wire        hw_standby_n,
  input  wire        sw_standby,
  // port 3 pad
  input  wire [7:0]  p3_in,
  output wire [7:0]  p3_out,
  output wire [7:0]  p3_oe_n,
  output wire [7:0]  p3_pullup_en,
  // external data bus and host data bus
  input  wire [7:0]  ext_bus_out,
  input  wire        ext_bus_drive,
  input  wire [7:0]  host_bus_out,
  input  wire        host_bus_drive,
  output wire [7:0]  p3_data_in,
  // port 4 pad
  input  wire [7:0]  p4_in,
  output wire [7:0]  p4_out,
  output wire [7:0]  p4_oe_n,
  // port 4 peripherals
  input  wire [7:0]  periph_out,
  input  wire [7:0]  periph_drive,
  input  wire [2:0]  host_irq,
  input  wire        sys_clk_level,
  output wire [7:0]  p4_data_in,
  output wire        periph_reinit,
  output wire        slave_mode
);

  ////////////////////////////////////////////////////////////////////////
  // synchronisers and device state

  wire [7:0] p3_pin_s;
  wire [7:0] p4_pin_s;
  wire [2:0] ctl_s;

  pgp_sync #(.W(8)) u_sync_p3 (
    .ref_clk  (ref_clk),
    .async_in (p3_in),
    .sync_out (p3_pin_s)
  );

  pgp_sync #(.W(8)) u_sync_p4 (
    .ref_clk  (ref_clk),
    .async_in (p4_in),
    .sync_out (p4_pin_s)
  );

  pgp_sync #(.W(3)) u_sync_ctl (
    .ref_clk  (ref_clk),
    .async_in ({hw_standby_n, mode_pins}),
    .sync_out (ctl_s)
  );

  wire [1:0] mode_s    = ctl_s[1:0];
  wire       hwstby    = ~ctl_s[2];
  wire       init      = ~rst_n | hwstby;
  wire       mode1     = (mode_s == `PGP_MODE_1);
  wire       expanded  = mode1 | (mode_s == `PGP_MODE_2);

  ////////////////////////////////////////////////////////////////////////
  // registers

  reg [7:0]  p3_pullup_q;
  reg [7:0]  p3_dir_q;
  reg [7:0]  p3_latch_q;
  reg [7:0]  p4_dir_q;
  reg [7:0]  p4_latch_q;
  reg        hie_q;
  reg        wait_q;
  reg [31:0] rdata_q;
  reg        slave_q;
  reg        reinit_q;
  reg [7:0]  p3_in_q;
  reg [7:0]  p4_in_q;

  wire       slave_d = ~expanded & hie_q;
  wire       req     = read | write;
  wire [15:0] idx    = address[17:2];
  wire       wr_go   = write & ~wait_q & byteenable[0];
  wire [7:0] wbyte   = writedata[7:0];
  wire [7:0] p4_dir_rst = expanded ? `PGP_P4_DIR_RST_EXP
                                   : `PGP_P4_DIR_RST_SGL;

  // one wait cycle, then a single ready cycle per request
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~(req & wait_q);
    end
  end

  // reset and hardware standby both initialise, soft standby retains
  always @(posedge ref_clk) begin
    if (init) begin
      p3_pullup_q <= `PGP_P3_PULLUP_RST;
      p3_dir_q    <= `PGP_P3_DIR_RST;
      p3_latch_q  <= `PGP_P3_LATCH_RST;
      p4_dir_q    <= p4_dir_rst;
      p4_latch_q  <= `PGP_P4_LATCH_RST;
      hie_q       <= 1'b0;
    end else begin
      if (wr_go && idx == `PGP_IDX_P3_PULLUP) begin
        p3_pullup_q <= wbyte;
      end
      if (wr_go && idx == `PGP_IDX_P3_DIR) begin
        p3_dir_q <= wbyte;
      end
      if (wr_go && idx == `PGP_IDX_P3_LATCH) begin
        p3_latch_q <= wbyte;
      end
      if (wr_go && idx == `PGP_IDX_P4_DIR) begin
        p4_dir_q <= wbyte;
      end
      if (expanded) begin
        p4_dir_q[`PGP_P4_CLK_PIN] <= 1'b1;
      end
      if (wr_go && idx == `PGP_IDX_P4_LATCH) begin
        p4_latch_q <= wbyte;
      end
      if (wr_go && idx == `PGP_IDX_SYS_CTRL) begin
        hie_q <= wbyte[`PGP_SYS_HIE_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path

  reg [7:0] rbyte;
  reg [7:0] p4_read;

  always @* begin
    p4_read = (p4_dir_q & p4_latch_q) | (~p4_dir_q & p4_pin_s);
    p4_read[`PGP_P4_CLK_PIN] = p4_pin_s[`PGP_P4_CLK_PIN];
    case (idx)
      `PGP_IDX_P3_PULLUP: rbyte = p3_pullup_q;
      `PGP_IDX_P3_DIR:    rbyte = `PGP_WO_READ;
      `PGP_IDX_P4_DIR:    rbyte = `PGP_WO_READ;
      `PGP_IDX_P3_LATCH:  rbyte = (p3_dir_q & p3_latch_q)
                                | (~p3_dir_q & p3_pin_s);
      `PGP_IDX_P4_LATCH:  rbyte = p4_read;
      `PGP_IDX_SYS_CTRL:  rbyte = {7'h00, hie_q};
      `PGP_IDX_STATUS:    rbyte = {4'h0, sw_standby, slave_q, mode_s};
      default:            rbyte = 8'h00;
    endcase
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (read && wait_q) begin
      rdata_q <= {24'h00_0000, rbyte};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state outputs

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      slave_q  <= 1'b0;
      reinit_q <= 1'b0;
      p3_in_q  <= 8'h00;
      p4_in_q  <= 8'h00;
    end else begin
      slave_q  <= slave_d;
      reinit_q <= sw_standby;
      p3_in_q  <= p3_pin_s;
      p4_in_q  <= p4_pin_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // port 3 pins

  reg [7:0] p3_out_q;
  reg [7:0] p3_oe_n_q;
  reg [7:0] p3_pu_q;

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_p3
      always @(posedge ref_clk) begin
        if (init) begin
          p3_out_q[i]  <= 1'b0;
          p3_oe_n_q[i] <= 1'b1;
          p3_pu_q[i]   <= 1'b0;
        end else begin
          p3_pu_q[i] <= p3_pullup_q[i] & ~p3_dir_q[i]
                      & ~mode1
                      & ~slave_d;
          if (expanded) begin
            p3_out_q[i]  <= ext_bus_out[i];
            p3_oe_n_q[i] <= ~(ext_bus_drive & ~sw_standby);
          end else if (slave_d) begin
            p3_out_q[i]  <= host_bus_out[i];
            p3_oe_n_q[i] <= ~host_bus_drive;
          end else begin
            p3_out_q[i]  <= p3_latch_q[i];
            p3_oe_n_q[i] <= ~p3_dir_q[i];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // port 4 pins

  reg [7:0] p4_out_q;
  reg [7:0] p4_oe_n_q;

  generate
    for (i = 0; i < 8; i = i + 1) begin : g_p4
      always @(posedge ref_clk) begin
        if (init) begin
          p4_out_q[i]  <= 1'b0;
          p4_oe_n_q[i] <= 1'b1;
        end else if (i == `PGP_P4_CLK_PIN) begin
          p4_out_q[i]  <= sys_clk_level;
          p4_oe_n_q[i] <= ~p4_dir_q[i];
        end else if (slave_d && p4_dir_q[i] &&
                     i >= `PGP_P4_HIRQ_LO && i <= `PGP_P4_HIRQ_HI) begin
          p4_out_q[i]  <= host_irq[i-`PGP_P4_HIRQ_LO];
          p4_oe_n_q[i] <= 1'b0;
        end else if (periph_drive[i] && !sw_standby) begin
          p4_out_q[i]  <= periph_out[i];
          p4_oe_n_q[i] <= 1'b0;
        end else begin
          p4_out_q[i]  <= p4_latch_q[i];
          p4_oe_n_q[i] <= ~p4_dir_q[i];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign waitrequest   = wait_q;
  assign readdata      = rdata_q;
  assign p3_out        = p3_out_q;
  assign p3_oe_n       = p3_oe_n_q;
  assign p3_pullup_en  = p3_pu_q;
  assign p3_data_in    = p3_in_q;
  assign p4_out        = p4_out_q;
  assign p4_oe_n       = p4_oe_n_q;
  assign p4_data_in    = p4_in_q;
  assign periph_reinit = reinit_q;
  assign slave_mode    = slave_q;

endmodule

// >>> verilog/pgp_sync.v
`timescale 1ns/1ps
module pgp_sync #(
  parameter W = 8
) (
  // clock
  input  wire         ref_clk,
  // async level in, synchronised level out
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // first stage feeds only the second
  always @(posedge ref_clk) begin
    meta_q <= async_in;
    sync_q <= meta_q;
  end

  assign sync_out = sync_q;

endmodule
